// [core/sswd_supervisor.sv]
`timescale 1ns/100ps
// What this block does
// - Active-high reset is always active-low's complement
// - Disabled gate drives chip-enable output high
// - Stalled watchdog input forces a reset timeout
// - Floating watchdog input disables the watchdog
// - Backup cell only when below threshold and cell
// - Main supply otherwise feeds the RAM output
// - Reset held at least the reset timeout
// - Supply dip restarts the reset timeout
// - Warning low below raised threshold, with hysteresis
// - Cell above main supply alone never resets
// - Watchdog timer cleared by reset or toggle
// - Watchdog idle during reset, counts after release
// - Chip-enable passes only outside reset
module sswd_supervisor
	import sswd_pkg::*;
#(
	parameter longint RESET_CYCLES = sswd_pkg::SSWD_RESET_CYCLES,
	parameter longint WATCHDOG_CYCLES = sswd_pkg::SSWD_WATCHDOG_CYCLES,
	parameter int TIMER_WIDTH = sswd_pkg::SSWD_TIMER_WIDTH
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic below_reset_cmp,
	input wire logic below_cell_cmp,
	input wire logic warn_fall_cmp,
	input wire logic warn_rise_cmp,
	input wire logic watchdog_input,
	input wire logic watchdog_mid_cmp,
	input wire logic chip_enable_in_n,
	output logic reset_out_n,
	output logic reset_out,
	output logic low_supply_warning_n,
	output logic backup_select,
	output logic chip_enable_out_n
);
	import sswd_pkg::*;

	// ----------------------------------------
	// Parameter checks
	// ----------------------------------------
	generate
		if (RESET_CYCLES < 2 || WATCHDOG_CYCLES < 2) begin : g_bad_cycles
			$error("sswd_supervisor timeouts must be at least two cycles");
		end
		if (TIMER_WIDTH < 2 || TIMER_WIDTH > 63) begin : g_bad_width
			$error("sswd_supervisor TIMER_WIDTH out of range");
		end
	endgenerate

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic rst_meta_reg;
	logic rst_q_reg;

	// Assert at once, release on the second edge
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_reg <= 1'b0;
			rst_q_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_q_reg <= rst_meta_reg;
		end
	end

	// ----------------------------------------
	// Input synchronisation
	// ----------------------------------------
	wire logic [SSWD_SYNC_WIDTH-1:0] raw_in = {
		chip_enable_in_n,
		watchdog_mid_cmp,
		watchdog_input,
		warn_rise_cmp,
		warn_fall_cmp,
		below_cell_cmp,
		below_reset_cmp
	};
	logic [SSWD_SYNC_WIDTH-1:0] filt;

	sswd_sync #(
		.WIDTH(SSWD_SYNC_WIDTH),
		.INIT(SSWD_SYNC_INIT)
	) u_sync (
		.clk(mclk),
		.rst_n(rst_q_reg),
		.d(raw_in),
		.q(filt)
	);

	wire logic below_reset = filt[SSWD_BIT_BELOW_RESET];
	wire logic below_cell = filt[SSWD_BIT_BELOW_CELL];
	wire logic warn_fall = filt[SSWD_BIT_WARN_FALL];
	wire logic warn_rise = filt[SSWD_BIT_WARN_RISE];
	wire logic wd_level = filt[SSWD_BIT_WATCHDOG];
	wire logic wd_mid = filt[SSWD_BIT_WATCHDOG_MID];
	wire logic ce_in_n = filt[SSWD_BIT_CHIP_ENABLE];

	// ----------------------------------------
	// Supervisor state and timers
	// ----------------------------------------
	sswd_state_t state_reg;
	sswd_state_t state_next;
	logic wd_prev_reg;
	logic [TIMER_WIDTH-1:0] rst_count;
	logic [TIMER_WIDTH-1:0] wd_count;
	logic rst_expired;
	logic wd_expired;

	wire logic in_hold = (state_reg == SSWD_HOLD);
	wire logic in_run = (state_reg == SSWD_RUN);
	wire logic wd_toggle = (wd_level != wd_prev_reg);
	wire logic wd_fire = wd_expired && in_run && !wd_mid;
	wire logic rst_clear = below_reset || in_run;
	wire logic wd_clear = !in_run || wd_toggle || wd_mid;
	wire logic wd_run = in_run && !wd_mid;

	sswd_timer #(
		.WIDTH(TIMER_WIDTH),
		.LIMIT(RESET_CYCLES)
	) u_reset_timer (
		.clk(mclk),
		.rst_n(rst_q_reg),
		.clear(rst_clear),
		.run(in_hold),
		.count(rst_count),
		.expired(rst_expired)
	);

	sswd_timer #(
		.WIDTH(TIMER_WIDTH),
		.LIMIT(WATCHDOG_CYCLES)
	) u_watchdog_timer (
		.clk(mclk),
		.rst_n(rst_q_reg),
		.clear(wd_clear),
		.run(wd_run),
		.count(wd_count),
		.expired(wd_expired)
	);

	// Backup cell level alone plays no part in leaving run
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			SSWD_HOLD: begin
				if (rst_expired && !below_reset) begin
					state_next = SSWD_RUN;
				end
			end
			SSWD_RUN: begin
				if (below_reset || wd_fire) begin
					state_next = SSWD_HOLD;
				end
			end
			default: begin
				state_next = SSWD_HOLD;
			end
		endcase
	end

	// ----------------------------------------
	// Output logic
	// ----------------------------------------
	logic reset_out_n_reg;
	logic reset_out_reg;
	logic warn_n_reg;
	logic warn_n_next;
	logic backup_reg;
	logic ce_out_n_reg;

	// Reset and chip-enable outputs follow the next state, so they move together
	wire logic reset_active_next = (state_next == SSWD_HOLD);
	wire logic backup_next = below_reset && below_cell;
	wire logic ce_out_n_next = reset_active_next ? 1'b1 : ce_in_n;

	// Fall threshold sets warning, rise threshold releases it
	always_comb begin
		warn_n_next = warn_n_reg;
		if (warn_fall) begin
			warn_n_next = 1'b0;
		end else if (warn_rise) begin
			warn_n_next = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rst_q_reg) begin
		if (!rst_q_reg) begin
			state_reg <= SSWD_STATE_INIT;
			wd_prev_reg <= 1'b0;
			reset_out_n_reg <= 1'b0;
			reset_out_reg <= 1'b1;
			warn_n_reg <= 1'b0;
			backup_reg <= 1'b0;
			ce_out_n_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			wd_prev_reg <= wd_level;
			reset_out_n_reg <= ~reset_active_next;
			reset_out_reg <= reset_active_next;
			warn_n_reg <= warn_n_next;
			backup_reg <= backup_next;
			ce_out_n_reg <= ce_out_n_next;
		end
	end

	assign reset_out_n = reset_out_n_reg;
	assign reset_out = reset_out_reg;
	assign low_supply_warning_n = warn_n_reg;
	assign backup_select = backup_reg;
	assign chip_enable_out_n = ce_out_n_reg;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Cycles with reset asserted, saturating
	logic [TIMER_WIDTH-1:0] hold_cnt_reg;
	localparam logic [TIMER_WIDTH-1:0] HOLD_MIN = TIMER_WIDTH'(RESET_CYCLES);
	wire logic hold_sat = &hold_cnt_reg;

	always_ff @(posedge mclk or negedge rst_q_reg) begin
		if (!rst_q_reg) begin
			hold_cnt_reg <= '0;
		end else if (!reset_out_reg) begin
			hold_cnt_reg <= '0;
		end else if (!hold_sat) begin
			hold_cnt_reg <= hold_cnt_reg + 1'b1;
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_q_reg);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------

	chk_reset_complement: assert property (reset_out_reg != reset_out_n_reg)
		else $error("reset outputs not complementary");
	chk_ce_gate_high: assert property (reset_out_reg |-> ce_out_n_reg)
		else $error("chip enable output low during reset");
	chk_ce_pass_path: assert property (!reset_out_reg |-> ce_out_n_reg == $past(ce_in_n))
		else $error("chip enable not passed in normal operation");
	chk_wd_fire_reset: assert property (wd_fire |=> reset_out_reg && !reset_out_n_reg)
		else $error("watchdog expiry did not assert reset");
	chk_wd_mid_off: assert property (wd_mid |=> wd_count == '0 && !wd_fire)
		else $error("floating watchdog input still counting");
	chk_backup_enter: assert property (below_reset && below_cell |=> backup_select)
		else $error("backup cell not selected");
	chk_backup_leave: assert property (!(below_reset && below_cell) |=> !backup_select)
		else $error("main supply not selected");
	chk_reset_hold_min: assert property ($fell(reset_out_reg) |-> $past(hold_cnt_reg) >= HOLD_MIN)
		else $error("reset released before timeout");
	chk_dip_restart: assert property (below_reset |=> rst_count == '0 && reset_out_reg)
		else $error("supply dip did not restart reset timeout");
	chk_warn_assert: assert property (warn_fall |=> !low_supply_warning_n)
		else $error("warning not asserted below threshold");
	chk_warn_keep: assert property (!warn_fall && !warn_rise |=> $stable(low_supply_warning_n))
		else $error("warning changed inside hysteresis band");
	chk_cell_no_reset: assert property (in_run && !below_reset && !wd_fire |=> in_run)
		else $error("reset without supply or watchdog cause");
	chk_wd_toggle_clr: assert property (in_run && wd_toggle |=> wd_count == '0)
		else $error("watchdog not cleared on toggle");
	chk_wd_idle_reset: assert property (in_hold |=> wd_count == '0)
		else $error("watchdog counted during reset");
	chk_wd_run_count: assert property (wd_run && !wd_clear && !wd_expired |=>
		wd_count == $past(wd_count) + 1'b1)
		else $error("watchdog not counting in normal operation");
	chk_wd_clear_after: assert property (wd_fire |-> ##2 wd_count == '0)
		else $error("watchdog not cleared after its reset");
	chk_backup_in_reset: assert property (backup_select |-> reset_out_reg)
		else $error("backup cell selected outside reset");
	chk_warn_release: assert property (!warn_fall && warn_rise |=> low_supply_warning_n)
		else $error("warning not released above threshold");
	chk_rst_no_early: assert property (in_hold && !rst_expired |=> in_hold)
		else $error("reset left before timer expiry");
	chk_timer_cleared_run: assert property (in_run |=> rst_count == '0)
		else $error("reset timer not cleared in normal operation");
	chk_power_hold: assert property (in_hold && below_reset |=> in_hold)
		else $error("reset released while supply low");

	// ----------------------------------------
	// Cover points
	// ----------------------------------------
	cov_watchdog_reset: cover property (wd_fire ##1 reset_out_reg);
	cov_reset_release: cover property ($fell(reset_out_reg));
	cov_backup_mode: cover property ($rose(backup_select));
	cov_warning: cover property ($fell(low_supply_warning_n));
	cov_dip_restart: cover property (in_hold && below_reset && rst_count != '0);
endmodule

// [common/sswd_pkg.sv]
package sswd_pkg;

	// ----------------------------------------
	// Timebase and timing
	// ----------------------------------------
	localparam int SSWD_CLK_KHZ = 200000;
	localparam int SSWD_RESET_TIMEOUT_MS = 200;
	// Watchdog timeout, 1.6 sec
	localparam int SSWD_WATCHDOG_TIMEOUT_MS = 1600;
	localparam longint SSWD_RESET_CYCLES = longint'(SSWD_RESET_TIMEOUT_MS) * SSWD_CLK_KHZ;
	localparam longint SSWD_WATCHDOG_CYCLES = longint'(SSWD_WATCHDOG_TIMEOUT_MS) * SSWD_CLK_KHZ;
	localparam int SSWD_TIMER_WIDTH = 32;

	// ----------------------------------------
	// Synchronised input vector layout
	// ----------------------------------------
	localparam int SSWD_SYNC_WIDTH = 7;
	localparam int SSWD_BIT_BELOW_RESET = 0;
	localparam int SSWD_BIT_BELOW_CELL = 1;
	localparam int SSWD_BIT_WARN_FALL = 2;
	localparam int SSWD_BIT_WARN_RISE = 3;
	localparam int SSWD_BIT_WATCHDOG = 4;
	localparam int SSWD_BIT_WATCHDOG_MID = 5;
	localparam int SSWD_BIT_CHIP_ENABLE = 6;
	// Assume low supply, floating watchdog, idle chip enable
	localparam logic [SSWD_SYNC_WIDTH-1:0] SSWD_SYNC_INIT = 7'h67;

	// ----------------------------------------
	// Supervisor states
	// ----------------------------------------
	typedef enum logic [1:0] {
		SSWD_HOLD = 2'b01,
		SSWD_RUN = 2'b10
	} sswd_state_t;

	localparam sswd_state_t SSWD_STATE_INIT = SSWD_HOLD;

endpackage

// [core/sswd_sync.sv]
`timescale 1ns/100ps
module sswd_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] q_reg;
	logic [WIDTH-1:0] q_next;
	wire logic [WIDTH-1:0] differ = s2_reg ^ s3_reg;

	generate
		if (WIDTH < 1) begin : g_bad
			$error("sswd_sync needs WIDTH of at least 1");
		end
	endgenerate

	// Take the new level only where the last two stages agree
	assign q_next = (~differ & s3_reg) | (differ & q_reg);
	assign q = q_reg;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_reg <= INIT;
			s2_reg <= INIT;
			s3_reg <= INIT;
			q_reg <= INIT;
		end else begin
			s1_reg <= d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			q_reg <= q_next;
		end
	end
endmodule

// [core/sswd_timer.sv]
`timescale 1ns/100ps
module sswd_timer #(
	parameter int WIDTH = 32,
	parameter longint LIMIT = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clear,
	input wire logic run,
	output logic [WIDTH-1:0] count,
	output logic expired
);
	localparam logic [WIDTH-1:0] LIM = WIDTH'(LIMIT);
	logic [WIDTH-1:0] count_reg;
	logic [WIDTH-1:0] count_next;
	wire logic at_limit = (count_reg == LIM);

	generate
		if (LIMIT < 1 || WIDTH < 1 || WIDTH > 63 ||
				(WIDTH < 63 && LIMIT >= (longint'(1) << WIDTH))) begin : g_bad
			$error("sswd_timer LIMIT does not fit WIDTH");
		end
	endgenerate

	// Clear wins; count saturates at the limit
	assign count_next = clear ? '0 : ((run && !at_limit) ? count_reg + 1'b1 : count_reg);
	assign count = count_reg;
	assign expired = at_limit;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= '0;
		end else begin
			count_reg <= count_next;
		end
	end
endmodule

// [verif/sswd_cpu_model.sv]
`timescale 1ns/100ps
module sswd_cpu_model (
	input wire logic mclk,
	input wire logic reset_out_n,
	input wire logic low_supply_warning_n,
	input wire logic toggle_en,
	input wire logic ce_req_n,
	output logic watchdog_input,
	output logic chip_enable_in_n
);
	int cnt = 0;
	logic wd_reg = 1'b0;
	logic ce_reg = 1'b1;
	assign watchdog_input = wd_reg;
	assign chip_enable_in_n = ce_reg;
	// ----------------------------------------
	// Program activity and RAM access
	// ----------------------------------------
	always @(posedge mclk) begin
		cnt <= (cnt == 9) ? 0 : cnt + 1;
		if (toggle_en && reset_out_n && cnt == 9)
			wd_reg <= #1 ~wd_reg;
		// Shutdown routine stops RAM access on warning
		ce_reg <= #1 ce_req_n | ~low_supply_warning_n;
	end
endmodule

// [verif/tb_supply_supervisor_reset_watchdog.sv]
`timescale 1ns/100ps
module tb_supply_supervisor_reset_watchdog;
	localparam longint RC = 20;
	localparam longint WD = 50;
	logic mclk, reset_n, below_reset_cmp, below_cell_cmp, warn_fall_cmp, warn_rise_cmp;
	logic watchdog_mid_cmp, toggle_en, ce_req_n, watchdog_input, chip_enable_in_n;
	logic reset_out_n, reset_out, low_supply_warning_n, backup_select, chip_enable_out_n;
	int mismatches = 0;
	int n_tests = 0;
	int cycles = 0;
	int n;

	sswd_supervisor #(.RESET_CYCLES(RC), .WATCHDOG_CYCLES(WD), .TIMER_WIDTH(32)) dut (
		.mclk(mclk), .reset_n(reset_n), .below_reset_cmp(below_reset_cmp),
		.below_cell_cmp(below_cell_cmp), .warn_fall_cmp(warn_fall_cmp),
		.warn_rise_cmp(warn_rise_cmp), .watchdog_input(watchdog_input),
		.watchdog_mid_cmp(watchdog_mid_cmp), .chip_enable_in_n(chip_enable_in_n),
		.reset_out_n(reset_out_n), .reset_out(reset_out),
		.low_supply_warning_n(low_supply_warning_n), .backup_select(backup_select),
		.chip_enable_out_n(chip_enable_out_n));

	sswd_cpu_model cpu (
		.mclk(mclk), .reset_out_n(reset_out_n), .low_supply_warning_n(low_supply_warning_n),
		.toggle_en(toggle_en), .ce_req_n(ce_req_n), .watchdog_input(watchdog_input),
		.chip_enable_in_n(chip_enable_in_n));

	// ----------------------------------------
	// Clock and hang guard
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 10000) begin
			mismatches++;
			report_and_stop();
		end
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic tick(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask
	task automatic chk(input string what, input logic exp, input logic got);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %b seen %b", what, exp, got);
		end
	endtask
	// Cycles until reset output reaches a level, bounded
	task automatic wait_rst(input logic lvl, output int k);
		k = 0;
		while (reset_out_n !== lvl && k < 400) begin
			tick(1);
			k++;
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_powerup();
		chk("reset_out_n", 1'b0, reset_out_n);
		chk("reset_out", 1'b1, reset_out);
		chk("chip_enable_out_n", 1'b1, chip_enable_out_n);
		below_reset_cmp = 1'b0;
		wait_rst(1'b1, n);
		chk("reset length", n >= RC && n <= RC + 10, 1'b1);
		chk("reset_out", 1'b0, reset_out);
		$display("done powerup");
	endtask
	task automatic t_dip();
		below_reset_cmp = 1'b1;
		tick(8);
		chk("reset_out_n", 1'b0, reset_out_n);
		below_reset_cmp = 1'b0;
		tick(10);
		below_reset_cmp = 1'b1;
		tick(4);
		below_reset_cmp = 1'b0;
		wait_rst(1'b1, n);
		chk("restarted length", n >= RC && n <= RC + 10, 1'b1);
		below_reset_cmp = 1'b1;
		tick(1);
		below_reset_cmp = 1'b0;
		tick(12);
		chk("glitch ignored", 1'b1, reset_out_n);
		$display("done dip");
	endtask
	task automatic t_watchdog();
		tick(200);
		chk("toggled no reset", 1'b1, reset_out_n);
		toggle_en = 1'b0;
		wait_rst(1'b0, n);
		chk("stall to reset", n >= WD - 10 && n <= WD + 10, 1'b1);
		wait_rst(1'b1, n);
		chk("watchdog reset length", n >= RC && n <= RC + 10, 1'b1);
		wait_rst(1'b0, n);
		chk("count from release", n >= WD - 2 && n <= WD + 10, 1'b1);
		toggle_en = 1'b1;
		wait_rst(1'b1, n);
		watchdog_mid_cmp = 1'b1;
		toggle_en = 1'b0;
		tick(3 * WD);
		chk("floating no reset", 1'b1, reset_out_n);
		toggle_en = 1'b1;
		tick(12);
		watchdog_mid_cmp = 1'b0;
		$display("done watchdog");
	endtask
	task automatic t_backup();
		for (int i = 0; i < 4; i++) begin
			below_reset_cmp = i[1];
			below_cell_cmp = i[0];
			tick(8);
			chk("backup_select", i[1] & i[0], backup_select);
			if (!i[1]) chk("cell high no reset", 1'b1, reset_out_n);
			below_reset_cmp = 1'b0;
			below_cell_cmp = 1'b0;
			wait_rst(1'b1, n);
		end
		$display("done backup");
	endtask
	task automatic t_warn();
		warn_fall_cmp = 1'b1;
		warn_rise_cmp = 1'b0;
		tick(8);
		chk("warning set", 1'b0, low_supply_warning_n);
		warn_fall_cmp = 1'b0;
		tick(8);
		chk("warning held", 1'b0, low_supply_warning_n);
		warn_rise_cmp = 1'b1;
		tick(8);
		chk("warning released", 1'b1, low_supply_warning_n);
		warn_rise_cmp = 1'b0;
		tick(8);
		chk("release held", 1'b1, low_supply_warning_n);
		warn_rise_cmp = 1'b1;
		$display("done warn");
	endtask
	task automatic t_ce();
		ce_req_n = 1'b0;
		tick(8);
		chk("ce pass low", 1'b0, chip_enable_out_n);
		ce_req_n = 1'b1;
		tick(8);
		chk("ce pass high", 1'b1, chip_enable_out_n);
		ce_req_n = 1'b0;
		below_reset_cmp = 1'b1;
		tick(8);
		chk("ce gated", 1'b1, chip_enable_out_n);
		chk("reset_out", 1'b1, reset_out);
		below_reset_cmp = 1'b0;
		wait_rst(1'b1, n);
		tick(2);
		chk("ce after release", 1'b0, chip_enable_out_n);
		ce_req_n = 1'b1;
		$display("done ce");
	endtask
	task automatic t_reset_mid();
		tick(5);
		reset_n = 1'b0;
		#1;
		chk("reset_out_n in reset", 1'b0, reset_out_n);
		chk("reset_out in reset", 1'b1, reset_out);
		chk("warning in reset", 1'b0, low_supply_warning_n);
		chk("ce in reset", 1'b1, chip_enable_out_n);
		tick(4);
		reset_n = 1'b1;
		wait_rst(1'b1, n);
		chk("second release length", n >= RC && n <= RC + 10, 1'b1);
		chk("reset_out after release", 1'b0, reset_out);
		$display("done reset_mid");
	endtask

	initial begin
		reset_n = 1'b0;
		below_reset_cmp = 1'b1;
		below_cell_cmp = 1'b0;
		warn_fall_cmp = 1'b0;
		warn_rise_cmp = 1'b1;
		watchdog_mid_cmp = 1'b0;
		toggle_en = 1'b1;
		ce_req_n = 1'b1;
		tick(16);
		reset_n = 1'b1;
		tick(3);
		t_powerup();
		t_dip();
		t_watchdog();
		t_backup();
		t_warn();
		t_ce();
		t_reset_mid();
		report_and_stop();
	end
endmodule
